/* File: led_sink_shift_latch_diag.sv */
// Operation
// - each rising serial clock shifts in serial_in and moves bits toward serial_out.
// - in error mode rising serial clocks step the diagnostic selection instead.
// - sink_enable_low low lets sinks follow data; high turns all sinks off.
// - in normal mode serial_out lags serial_in by 8.5 serial clock cycles.
// - in global error mode serial_out carries flag while serial_in is high: 0 fault, 1 no fault; serial_in low gives 0.
// - separate data register holds shown pattern; shifting never disturbs outputs.
// - sixteen sinks, one data bit each; shift and data registers are 16 bits.
// - store overtemp, open and short results; global flag plus detailed reports.
// - low-current diagnostic mode drives only a small test current.
// - serial clock edges are sampled by the 50 MHz mclk, so shifting works only up to 25 MHz.
// - rising load strobe copies the shift register into the data register.
// - frames are most significant bit first.
// - rising load strobe with enable high enters error mode; clock must be low.
// - pulse count 0 temp, 1 open, 2 short, 3 low current, 4 shutdown by input.
`default_nettype none
module led_sink_shift_latch_diag #(
	parameter int unsigned CHANNELS = led_sink_pkg::CHANNELS
) (
	// clock and reset
	input  wire logic                mclk,
	input  wire logic                rst_n,
	// serial pins
	input  wire logic                sclk,
	input  wire logic                serial_in,
	output logic                     serial_out,
	// load and enable
	input  wire logic                load_strobe,
	input  wire logic                sink_enable_low,
	// analog sense results, low means fault
	input  wire logic                overtemp_ok,
	input  wire logic [CHANNELS-1:0] open_ok,
	input  wire logic [CHANNELS-1:0] short_ok,
	// sink controls
	output logic      [CHANNELS-1:0] sink_outputs,
	output logic                     low_current,
	output logic                     shutdown,
	// status
	output logic                     error_mode,
	output logic                     overtemp_flag,
	output logic                     open_load_flag,
	output logic                     short_load_flag,
	output logic                     testing_met
);
	led_sink_pkg::pins_s     pins;
	led_sink_pkg::diag_sel_e sel;
	logic [3:0]              rise;
	logic [3:0]              fall;
	logic [CHANNELS-1:0]     shift_reg;
	logic [CHANNELS-1:0]     data_reg;
	logic                    half_bit;
	logic [CHANNELS-1:0]     open_det;
	logic [CHANNELS-1:0]     short_det;
	logic                    temp_det;
	logic [15:0]             low_count;
	logic [CHANNELS-1:0]     open_seen;
	logic [CHANNELS-1:0]     short_seen;
	logic [CHANNELS-1:0]     next_sink_outputs;

	assign pins = '{sclk: sclk, serial_in: serial_in, load_strobe: load_strobe,
		sink_enable_low: sink_enable_low};

	edge_detect #(.WIDTH(4)) u_edges (
		.mclk  (mclk),
		.rst_n (rst_n),
		.level (pins),
		.rise  (rise),
		.fall  (fall)
	);

	wire sclk_rise   = rise[3];
	wire sclk_fall   = fall[3];
	wire load_rise   = rise[1];
	wire load_fall   = fall[1];
	wire enable_rise = rise[0];
	wire enter_error = load_rise && sink_enable_low && !sclk;
	wire sel_step    = error_mode && sclk_rise && (sel != led_sink_pkg::SEL_SHUTDOWN);
	// sinks under test: only lit channels can be evaluated
	wire [CHANNELS-1:0] lit = data_reg;
	wire global_flag = (sel == led_sink_pkg::SEL_OPEN)  ? open_load_flag :
		(sel == led_sink_pkg::SEL_SHORT) ? short_load_flag : overtemp_flag;
	wire [CHANNELS-1:0] report = (sel == led_sink_pkg::SEL_OPEN)  ? open_det :
		(sel == led_sink_pkg::SEL_SHORT) ? short_det : {CHANNELS{temp_det}};

	// serial shift register, msb first: bits move toward msb, serial_out taps bit CHANNELS/2
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			shift_reg <= led_sink_pkg::DATA_RESET;
		else if (error_mode && load_fall)
			shift_reg <= report;
		else if (sclk_rise && !error_mode)
			shift_reg <= {shift_reg[CHANNELS-2:0], serial_in};
	end

	// serial_out updates on falling sclk: half-cycle extra gives 8.5 cycle lag
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			half_bit <= 1'b0;
		else if (sclk_fall)
			half_bit <= shift_reg[CHANNELS/2];
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			serial_out <= 1'b1;
		else if (error_mode)
			serial_out <= global_flag & serial_in;
		else
			serial_out <= half_bit;
	end

	// data register loads only on rising load strobe
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			data_reg <= led_sink_pkg::DATA_RESET;
		else if (load_rise && !error_mode)
			data_reg <= shift_reg;
	end

	// error mode entry and selection stepping
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			error_mode <= 1'b0;
			sel        <= led_sink_pkg::SEL_OVERTEMP;
		end
		else if (enter_error)
		begin
			error_mode <= 1'b1;
			sel        <= led_sink_pkg::SEL_OVERTEMP;
		end
		else if (error_mode && load_fall)
			error_mode <= 1'b0;
		else if (sel_step)
			sel <= led_sink_pkg::diag_sel_e'(sel + 3'h1);
	end

	// shutdown chosen by serial_in when fourth pulse selects it
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			shutdown <= 1'b0;
		else if (error_mode && sel == led_sink_pkg::SEL_SHUTDOWN)
			shutdown <= !serial_in;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			low_current <= 1'b0;
		else if (error_mode && sel == led_sink_pkg::SEL_LOWCUR)
			low_current <= 1'b1;
		else if (!error_mode && load_rise)
			low_current <= 1'b0;
	end

	// measure enable low time for fault evaluation
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			low_count <= 16'h0000;
		else if (sink_enable_low)
			low_count <= 16'h0000;
		else if (low_count < 16'(led_sink_pkg::TESTING_CYC))
			low_count <= low_count + 16'h0001;
	end

	assign testing_met = (low_count >= 16'(led_sink_pkg::TESTING_CYC));

	// fault capture on rising enable, untested channels read as good
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			open_det        <= '1;
			short_det       <= '1;
			temp_det        <= 1'b1;
			overtemp_flag   <= 1'b1;
			open_load_flag  <= 1'b1;
			short_load_flag <= 1'b1;
		end
		else if (error_mode && enable_rise)
		begin
			open_det        <= open_seen;
			short_det       <= short_seen;
			temp_det        <= overtemp_ok;
			overtemp_flag   <= overtemp_ok;
			open_load_flag  <= &open_seen;
			short_load_flag <= &short_seen;
		end
	end

	// per-channel gating: a sink conducts only when its data bit is set,
	// the enable is low and the device is awake
	generate
		for (genvar ch = 0; ch < CHANNELS; ch++)
		begin : g_channel
			assign next_sink_outputs[ch] = data_reg[ch] && !sink_enable_low && !shutdown;
			// an unlit sink cannot be judged, so it reads as good
			assign open_seen[ch]  = open_ok[ch] || !lit[ch];
			assign short_seen[ch] = short_ok[ch] || !lit[ch];
		end
	endgenerate

	// sinks come from flip-flops so enable edges never glitch them
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			sink_outputs <= '0;
		else
			sink_outputs <= next_sink_outputs;
	end
endmodule // led_sink_shift_latch_diag
`default_nettype wire

/* File: led_sink_pkg.sv */
`default_nettype none
package led_sink_pkg;
	localparam int unsigned CHANNELS    = 16;
	localparam int unsigned CLK_MHZ     = 50;
	localparam int unsigned SCLK_MAX_MHZ = 50;
	// output enable low time needed for fault evaluation, in ns
	localparam int unsigned TESTING_NS  = 2000;
	localparam int unsigned TESTING_CYC = (TESTING_NS * CLK_MHZ) / 1000;
	localparam logic [CHANNELS-1:0] DATA_RESET = 16'h0000;

	typedef enum logic [2:0] {
		SEL_OVERTEMP,
		SEL_OPEN,
		SEL_SHORT,
		SEL_LOWCUR,
		SEL_SHUTDOWN
	} diag_sel_e;

	// sampled pin levels
	typedef struct packed {
		logic sclk;
		logic serial_in;
		logic load_strobe;
		logic sink_enable_low;
	} pins_s;

	// overtemp and per-channel sense results, 0 means fault
	typedef struct packed {
		logic                overtemp_ok;
		logic [CHANNELS-1:0] open_ok;
		logic [CHANNELS-1:0] short_ok;
	} sense_s;
endpackage
`default_nettype wire

/* File: edge_detect.sv */
`default_nettype none
module edge_detect #(
	parameter int unsigned WIDTH = 4
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_n,
	// sampled levels
	input  wire logic [WIDTH-1:0] level,
	// edge strobes
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] prev;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			prev <= '0;
		else
			prev <= level;
	end

	assign rise = level & ~prev;
	assign fall = ~level & prev;
endmodule // edge_detect
`default_nettype wire

/* File: led_sink_props.sv */
`default_nettype none
module led_sink_props #(
	parameter int unsigned CHANNELS = 16
) (
	// clock and pins
	input wire logic                mclk,
	input wire logic                rst_n,
	input wire logic                sclk,
	input wire logic                serial_in,
	input wire logic                serial_out,
	input wire logic                load_strobe,
	input wire logic                sink_enable_low,
	// outputs
	input wire logic [CHANNELS-1:0] sink_outputs,
	input wire logic                shutdown,
	input wire logic                error_mode,
	input wire logic                overtemp_flag,
	input wire logic                open_load_flag,
	input wire logic                short_load_flag,
	input wire logic                testing_met
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_off; sink_enable_low[*2] |-> sink_outputs == '0; endproperty
	a_off: assert property (p_off) else $error("sink on");
	property p_hold;
		(!load_strobe && $stable({sink_enable_low, shutdown}))[*3] |-> $stable(sink_outputs);
	endproperty
	a_hold: assert property (p_hold) else $error("sinks moved");
	property p_enter; $rose(load_strobe) && sink_enable_low && !sclk |-> ##[1:3] error_mode; endproperty
	a_enter: assert property (p_enter) else $error("no error mode");
	property p_gate; (error_mode && !serial_in)[*3] |-> !serial_out; endproperty
	a_gate: assert property (p_gate) else $error("flag not gated");
	property p_flag;
		(error_mode && serial_in && overtemp_flag && open_load_flag && short_load_flag)[*3]
			|-> serial_out;
	endproperty
	a_flag: assert property (p_flag) else $error("flag low");
	property p_norm; (!error_mode && $stable(sclk))[*4] |-> $stable(serial_out); endproperty
	a_norm: assert property (p_norm) else $error("output moved");
	property p_shut; $rose(shutdown) |-> $past(error_mode); endproperty
	a_shut: assert property (p_shut) else $error("sleep outside");
	property p_test; $fell(sink_enable_low) |=> !testing_met[*8]; endproperty
	a_test: assert property (p_test) else $error("met early");
endmodule // led_sink_props
bind led_sink_shift_latch_diag led_sink_props #(.CHANNELS(CHANNELS)) i_led_sink_props (
	.mclk            (mclk),
	.rst_n           (rst_n),
	.sclk            (sclk),
	.serial_in       (serial_in),
	.serial_out      (serial_out),
	.load_strobe     (load_strobe),
	.sink_enable_low (sink_enable_low),
	.sink_outputs    (sink_outputs),
	.shutdown        (shutdown),
	.error_mode      (error_mode),
	.overtemp_flag   (overtemp_flag),
	.open_load_flag  (open_load_flag),
	.short_load_flag (short_load_flag),
	.testing_met     (testing_met)
);
`default_nettype wire

/* File: host_model.sv */
`default_nettype none
module host_model (
	input  wire logic mclk,
	output logic      sclk,
	output logic      serial_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		sclk = 1'b0;
		serial_in = 1'b1;
	end
	// four mclk a bit gives 12.5 MHz
	task automatic send(input logic [15:0] w, input int n);
		for (int i = 15; i > 15 - n; i--)
		begin
			serial_in <= w[i];
			repeat (2) @(posedge mclk);
			sclk <= 1'b1;
			repeat (2) @(posedge mclk);
			sclk <= 1'b0;
		end
	endtask
endmodule // host_model
`default_nettype wire

/* File: testbench.sv */
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
	$display("mismatch at %0t: value differs", $time); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        load_strobe = 1'b0;
	logic        sink_enable_low = 1'b1;
	logic        overtemp_ok = 1'b1;
	logic [15:0] open_ok = 16'hffff;
	logic [15:0] short_ok = 16'hffff;
	logic        sclk, serial_in, serial_out, low_current, shutdown, error_mode;
	logic        overtemp_flag, open_load_flag, short_load_flag, testing_met;
	logic [15:0] sink_outputs;
	int          err_total = 0;
	int          num_checks = 0;
	always #10 mclk = ~mclk;
	host_model i_host_model (.mclk(mclk), .sclk(sclk), .serial_in(serial_in));
	led_sink_shift_latch_diag i_led_sink_shift_latch_diag (.mclk(mclk), .rst_n(rst_n),
		.sclk(sclk), .serial_in(serial_in), .serial_out(serial_out), .load_strobe(load_strobe),
		.sink_enable_low(sink_enable_low), .overtemp_ok(overtemp_ok), .open_ok(open_ok),
		.short_ok(short_ok), .sink_outputs(sink_outputs), .low_current(low_current),
		.shutdown(shutdown), .error_mode(error_mode), .overtemp_flag(overtemp_flag),
		.open_load_flag(open_load_flag), .short_load_flag(short_load_flag),
		.testing_met(testing_met));
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// error session: select pulses, then enable low for 2200 ns
	task automatic diag(input int n, input logic si, input logic ok);
		overtemp_ok <= ok;
		sink_enable_low <= 1'b1;
		tick(3);
		load_strobe <= 1'b1;
		tick(4);
		i_host_model.send(si ? 16'hffff : 16'h0000, n);
		tick(2);
		sink_enable_low <= 1'b0;
		tick(90);
		`CHK(testing_met, 1'b0)
		tick(20);
		`CHK(testing_met, 1'b1)
		sink_enable_low <= 1'b1;
		tick(6);
	endtask
	task automatic leave();
		load_strobe <= 1'b0;
		tick(5);
		`CHK(error_mode, 1'b0)
		$display("test done at %0t", $time);
	endtask
	// normal load of what the shift register holds, shown on the sinks
	task automatic show(input logic [15:0] exp);
		sink_enable_low <= 1'b0;
		tick(2);
		load_strobe <= 1'b1;
		tick(4);
		load_strobe <= 1'b0;
		tick(5);
		`CHK(sink_outputs, exp)
		`CHK(low_current, 1'b0)
	endtask
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#100000;
		err_total++;
		give_verdict();
	end
	initial
	begin
		tick(8);
		rst_n <= 1'b1;
		sink_enable_low <= 1'b0;
		tick(2);
		i_host_model.send(16'ha5c3, 16);
		tick(2);
		load_strobe <= 1'b1;
		tick(4);
		load_strobe <= 1'b0;
		tick(5);
		`CHK(sink_outputs, 16'ha5c3)
		i_host_model.send(16'h3d5b, 16);
		tick(5);
		`CHK(sink_outputs, 16'ha5c3)
		// bit 8 of the frame left 8.5 clocks before the last falling sclk
		`CHK(serial_out, 1'b1)
		sink_enable_low <= 1'b1;
		tick(5);
		`CHK(sink_outputs, 16'h0000)
		$display("test done at %0t", $time);
		diag(0, 1'b1, 1'b0);
		`CHK({error_mode, serial_out}, 2'b10)
		`CHK(overtemp_flag, 1'b0)
		leave();
		diag(0, 1'b1, 1'b1);
		`CHK(serial_out, 1'b1)
		leave();
		diag(3, 1'b1, 1'b1);
		`CHK({low_current, sink_outputs}, {1'b1, 16'h0000})
		leave();
		open_ok <= 16'hfeff;
		diag(1, 1'b1, 1'b1);
		`CHK({open_load_flag, short_load_flag, serial_out}, 3'b010)
		leave();
		show(16'hfeff);
		open_ok <= 16'hffff;
		short_ok <= 16'h7eff;
		diag(2, 1'b1, 1'b1);
		`CHK({open_load_flag, short_load_flag, serial_out}, 3'b100)
		leave();
		// channel 8 was unlit during the test, so it reads as good
		show(16'h7fff);
		short_ok <= 16'hffff;
		diag(4, 1'b0, 1'b1);
		`CHK(shutdown, 1'b1)
		`CHK(serial_out, 1'b0)
		leave();
		sink_enable_low <= 1'b0;
		tick(5);
		`CHK(sink_outputs, 16'h0000)
		diag(4, 1'b1, 1'b1);
		`CHK(shutdown, 1'b0)
		leave();
		show(16'hffff);
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
